//--- rail_fault_mask_discharge_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rail_fault_mask_discharge_regs
  import rail_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = 7'h2A,  // Slave address, arbitrary value
  parameter bit         VARIANT_ALT = 1'b0    // Factory variant select
) (
  input  wire logic                 clk,                  // Device clock, 200 MHz
  input  wire logic                 rst,                  // Async reset, active high
  input  wire logic                 scl_in,               // Serial clock pin
  input  wire logic                 sda_in,               // Serial data pin level
  output logic                      sda_out,              // Serial data drive value
  output logic                      sda_oe,               // Serial data drive enable
  input  wire logic [NUM_RAILS-1:0] rail_fault_in,        // Rail fault comparators
  output logic                      shutdown_req,         // Device shutdown request
  output logic                      ddr_term_discharge,   // DDR term 100 ohm discharge on
  output logic      [1:0]           aux_ldo_discharge_sel,// Aux LDO discharge choice
  output logic                      aux_ldo_shutdown_keep,// Aux LDO kept in shutdown
  output logic      [3:0]           aux_ldo_voltage_code, // Aux LDO output code
  output logic                      aux_ldo_enable,       // Aux LDO enable bit
  output logic                      aux_ldo_run           // Aux LDO actually on
);

  localparam logic [7:0] AUXCTL_RESET = VARIANT_ALT ? AUXCTL_RESET_ALT : AUXCTL_RESET_MAIN;

  // Pin synchronisers and edge history
  logic         scl_s1_reg;
  logic         scl_s2_reg;
  logic         scl_d_reg;
  logic         sda_s1_reg;
  logic         sda_s2_reg;
  logic         sda_d_reg;
  logic         scl_rise;
  logic         scl_fall;
  logic         bus_start;
  logic         bus_stop;

  // Slave state
  slave_state_t state_reg;
  slave_state_t state_next;
  logic [2:0]   cnt_reg;
  logic [2:0]   cnt_next;
  logic [7:0]   shift_reg;
  logic [7:0]   shift_next;
  logic [7:0]   ptr_reg;
  logic [7:0]   ptr_next;
  logic         rw_reg;
  logic         rw_next;
  logic         have_ptr_reg;
  logic         have_ptr_next;
  logic         oe_reg;
  logic         oe_next;
  logic         wr_en;
  logic [7:0]   wr_data;
  logic [7:0]   rd_data;

  // Register bank
  logic [7:0]   mask2_reg;
  logic [7:0]   mask2_next;
  logic [7:0]   disch4_reg;
  logic [7:0]   disch4_next;
  logic [7:0]   auxctl_reg;
  logic [7:0]   auxctl_next;

  // Fault bank links
  logic [NUM_RAILS-1:0] rail_flag;
  logic [NUM_RAILS-1:0] rail_masked;
  logic [NUM_RAILS-1:0] flag_clear;
  logic [7:0]           flags_view;

  // Bus condition detection on synchronised pins
  always_comb begin
    scl_rise  = scl_s2_reg & ~scl_d_reg;
    scl_fall  = ~scl_s2_reg & scl_d_reg;
    bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    bus_stop  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
  end

  // Read data decode
  always_comb begin
    if (ptr_reg == MASK2_ADDR) begin
      rd_data = mask2_reg;
    end else if (ptr_reg == DISCH4_ADDR) begin
      rd_data = disch4_reg;
    end else if (ptr_reg == AUXCTL_ADDR) begin
      rd_data = auxctl_reg;
    end else if (ptr_reg == FLAGS_ADDR) begin
      rd_data = flags_view;
    end else begin
      rd_data = 8'h00;
    end
  end

  // Serial slave next state
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    ptr_next      = ptr_reg;
    rw_next       = rw_reg;
    have_ptr_next = have_ptr_reg;
    oe_next       = oe_reg;
    wr_en         = 1'b0;
    wr_data       = {shift_reg[6:0], sda_s2_reg};
    if (bus_start) begin
      state_next    = ST_ADDR;
      cnt_next      = 3'h0;
      have_ptr_next = 1'b0;
      oe_next       = 1'b0;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s2_reg};
            cnt_next   = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              if (shift_reg[6:0] == DEV_ADDR) begin
                rw_next    = sda_s2_reg;
                state_next = ST_WAIT_ACK;
              end else begin
                state_next = ST_IDLE;
              end
            end
          end
        end
        ST_REG: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s2_reg};
            cnt_next   = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              ptr_next      = wr_data;
              have_ptr_next = 1'b1;
              state_next    = ST_WAIT_ACK;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s2_reg};
            cnt_next   = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              wr_en      = 1'b1;
              ptr_next   = ptr_reg + 8'h01;
              state_next = ST_WAIT_ACK;
            end
          end
        end
        ST_WAIT_ACK: begin
          if (scl_fall) begin
            oe_next    = 1'b1;
            state_next = ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_next = 3'h0;
            if (rw_reg) begin
              shift_next = rd_data;
              oe_next    = ~rd_data[7];
              ptr_next   = ptr_reg + 8'h01;
              state_next = ST_RDATA;
            end else begin
              oe_next    = 1'b0;
              state_next = have_ptr_reg ? ST_WDATA : ST_REG;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_reg == 3'h7) begin
              oe_next    = 1'b0;
              state_next = ST_RACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = ~shift_reg[6];
              cnt_next   = cnt_reg + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            state_next = sda_s2_reg ? ST_IDLE : ST_RLOAD;
          end
        end
        ST_RLOAD: begin
          if (scl_fall) begin
            shift_next = rd_data;
            oe_next    = ~rd_data[7];
            ptr_next   = ptr_reg + 8'h01;
            cnt_next   = 3'h0;
            state_next = ST_RDATA;
          end
        end
        default: begin
          oe_next    = 1'b0;
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Register bank writes; fixed bits hold their reset value
  always_comb begin
    mask2_next  = mask2_reg;
    disch4_next = disch4_reg;
    auxctl_next = auxctl_reg;
    flag_clear  = '0;
    if (wr_en) begin
      if (ptr_reg == MASK2_ADDR) begin
        mask2_next = (wr_data & MASK2_WMASK) | (MASK2_RESET & ~MASK2_WMASK);
      end else if (ptr_reg == DISCH4_ADDR) begin
        disch4_next = (wr_data & DISCH4_WMASK) | (DISCH4_RESET & ~DISCH4_WMASK);
      end else if (ptr_reg == AUXCTL_ADDR) begin
        auxctl_next = wr_data;
      end else if (ptr_reg == FLAGS_ADDR) begin
        flag_clear[RAIL_LOWV]   = wr_data[LOWV_MASK_BIT];
        flag_clear[RAIL_SWPAIR] = wr_data[SWPAIR_MASK_HI];
        flag_clear[RAIL_DDR]    = wr_data[DDR_MASK_BIT];
        flag_clear[RAIL_AUX]    = wr_data[AUX_MASK_BIT];
        flag_clear[RAIL_ANALOG] = wr_data[ANALOG_MASK_BIT];
      end
    end
  end

  // Mask bits to per-rail mask
  always_comb begin
    rail_masked[RAIL_ANALOG] = mask2_reg[ANALOG_MASK_BIT];
    rail_masked[RAIL_AUX]    = mask2_reg[AUX_MASK_BIT];
    rail_masked[RAIL_DDR]    = mask2_reg[DDR_MASK_BIT];
    rail_masked[RAIL_SWPAIR] = (mask2_reg[SWPAIR_MASK_HI:SWPAIR_MASK_LO] == SWPAIR_MASKED);
    rail_masked[RAIL_LOWV]   = mask2_reg[LOWV_MASK_BIT];
    flags_view = {2'b00, rail_flag[RAIL_ANALOG], rail_flag[RAIL_AUX], rail_flag[RAIL_DDR],
                  rail_flag[RAIL_SWPAIR], 1'b0, rail_flag[RAIL_LOWV]} & FLAGS_WMASK;
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s1_reg   <= 1'b1;
      scl_s2_reg   <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_s1_reg   <= 1'b1;
      sda_s2_reg   <= 1'b1;
      sda_d_reg    <= 1'b1;
      state_reg    <= ST_IDLE;
      cnt_reg      <= 3'h0;
      shift_reg    <= 8'h00;
      ptr_reg      <= 8'h00;
      rw_reg       <= 1'b0;
      have_ptr_reg <= 1'b0;
      oe_reg       <= 1'b0;
      mask2_reg    <= MASK2_RESET;
      disch4_reg   <= DISCH4_RESET;
      auxctl_reg   <= AUXCTL_RESET;
    end else begin
      scl_s1_reg   <= scl_in;
      scl_s2_reg   <= scl_s1_reg;
      scl_d_reg    <= scl_s2_reg;
      sda_s1_reg   <= sda_in;
      sda_s2_reg   <= sda_s1_reg;
      sda_d_reg    <= sda_s2_reg;
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      ptr_reg      <= ptr_next;
      rw_reg       <= rw_next;
      have_ptr_reg <= have_ptr_next;
      oe_reg       <= oe_next;
      mask2_reg    <= mask2_next;
      disch4_reg   <= disch4_next;
      auxctl_reg   <= auxctl_next;
    end
  end

  // Fault flag latches and shutdown decision
  rail_fault_latch u_fault (
    .clk          (clk),
    .rst          (rst),
    .fault_raw    (rail_fault_in),
    .flag_clear   (flag_clear),
    .rail_masked  (rail_masked),
    .flag         (rail_flag),
    .shutdown_req (shutdown_req)
  );

  // Open-drain data pin and control outputs
  assign sda_out               = 1'b0;
  assign sda_oe                = oe_reg;
  assign ddr_term_discharge    = disch4_reg[DDR_DISCH_BIT];
  assign aux_ldo_discharge_sel = auxctl_reg[AUX_DISCH_HI:AUX_DISCH_LO];
  assign aux_ldo_shutdown_keep = auxctl_reg[AUX_KEEP_BIT];
  assign aux_ldo_voltage_code  = auxctl_reg[AUX_VCODE_HI:AUX_VCODE_LO];
  assign aux_ldo_enable        = auxctl_reg[AUX_EN_BIT];
  assign aux_ldo_run           = auxctl_reg[AUX_EN_BIT] &
                                 (~shutdown_req | auxctl_reg[AUX_KEEP_BIT]);

endmodule // rail_fault_mask_discharge_regs
`default_nettype wire

//--- rail_regs_pkg.sv
package rail_regs_pkg;

  // Register addresses
  localparam logic [7:0] MASK2_ADDR   = 8'hA3;
  localparam logic [7:0] DISCH4_ADDR  = 8'hAD;
  localparam logic [7:0] AUXCTL_ADDR  = 8'hAE;
  localparam logic [7:0] FLAGS_ADDR   = 8'hB3;

  // Reset values and writable bits
  localparam logic [7:0] MASK2_RESET  = 8'h37;
  localparam logic [7:0] MASK2_WMASK  = 8'h3F;
  localparam logic [7:0] DISCH4_RESET = 8'h61;
  localparam logic [7:0] DISCH4_WMASK = 8'h10;
  localparam logic [7:0] AUXCTL_RESET_MAIN = 8'h7C;
  localparam logic [7:0] AUXCTL_RESET_ALT  = 8'h69;
  localparam logic [7:0] FLAGS_WMASK  = 8'h3D;

  // Field positions
  localparam int ANALOG_MASK_BIT  = 5;
  localparam int AUX_MASK_BIT     = 4;
  localparam int DDR_MASK_BIT     = 3;
  localparam int SWPAIR_MASK_HI   = 2;
  localparam int SWPAIR_MASK_LO   = 1;
  localparam int LOWV_MASK_BIT    = 0;
  localparam int DDR_DISCH_BIT    = 4;
  localparam int AUX_DISCH_HI     = 7;
  localparam int AUX_DISCH_LO     = 6;
  localparam int AUX_KEEP_BIT     = 5;
  localparam int AUX_VCODE_HI     = 4;
  localparam int AUX_VCODE_LO     = 1;
  localparam int AUX_EN_BIT       = 0;
  localparam logic [1:0] SWPAIR_MASKED = 2'h3;

  // Rail indices of the fault flag bank
  localparam int NUM_RAILS   = 5;
  localparam int RAIL_LOWV   = 0;
  localparam int RAIL_SWPAIR = 1;
  localparam int RAIL_DDR    = 2;
  localparam int RAIL_AUX    = 3;
  localparam int RAIL_ANALOG = 4;

  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_WAIT_ACK  = 4'h2,
    ST_ACK       = 4'h3,
    ST_REG       = 4'h4,
    ST_WDATA     = 4'h5,
    ST_RDATA     = 4'h6,
    ST_RACK      = 4'h7,
    ST_RLOAD     = 4'h8
  } slave_state_t;

endpackage

//--- rail_fault_latch.sv
`timescale 1ns/1ps
`default_nettype none
module rail_fault_latch
  import rail_regs_pkg::*;
(
  input  wire logic                 clk,          // Device clock
  input  wire logic                 rst,          // Async reset, active high
  input  wire logic [NUM_RAILS-1:0] fault_raw,    // Rail out of regulation, async
  input  wire logic [NUM_RAILS-1:0] flag_clear,   // Write-one-clear strobes
  input  wire logic [NUM_RAILS-1:0] rail_masked,  // Per-rail mask in effect
  output logic      [NUM_RAILS-1:0] flag,         // Latched fault flags
  output logic                      shutdown_req  // Unmasked fault present
);

  logic [NUM_RAILS-1:0] sync1_reg;
  logic [NUM_RAILS-1:0] sync2_reg;
  logic [NUM_RAILS-1:0] flag_reg;
  logic [NUM_RAILS-1:0] flag_next;
  logic                 shut_reg;
  logic                 shut_next;

  // Per-rail sticky flag, set beats clear
  genvar i;
  generate
    for (i = 0; i < NUM_RAILS; i++) begin : g_rail
      always_comb begin
        flag_next[i] = sync2_reg[i] | (flag_reg[i] & ~flag_clear[i]);
      end
    end
  endgenerate

  // Shutdown on any latched, unmasked fault
  always_comb begin
    shut_next = |(flag_next & ~rail_masked);
  end

  // Synchroniser and flag registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      flag_reg  <= '0;
      shut_reg  <= 1'b0;
    end else begin
      sync1_reg <= fault_raw;
      sync2_reg <= sync1_reg;
      flag_reg  <= flag_next;
      shut_reg  <= shut_next;
    end
  end

  assign flag         = flag_reg;
  assign shutdown_req = shut_reg;

endmodule // rail_fault_latch
`default_nettype wire

//--- rail_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rail_regs_chk
  import rail_regs_pkg::*;
#(
  parameter bit VARIANT_ALT = 1'b0  // Factory variant select
) (
  input wire logic                 clk,                   // Device clock
  input wire logic                 rst,                   // Async reset
  input wire logic                 scl_in,                // Serial clock pin
  input wire logic                 sda_out,               // Data drive value
  input wire logic                 sda_oe,                // Data drive enable
  input wire logic [NUM_RAILS-1:0] rail_fault_in,         // Rail faults
  input wire logic                 shutdown_req,          // Shutdown request
  input wire logic                 ddr_term_discharge,    // DDR discharge
  input wire logic [1:0]           aux_ldo_discharge_sel, // Aux discharge
  input wire logic                 aux_ldo_shutdown_keep, // Aux keep
  input wire logic [3:0]           aux_ldo_voltage_code,  // Aux code
  input wire logic                 aux_ldo_enable,        // Aux enable
  input wire logic                 aux_ldo_run            // Aux on
);
  localparam logic [7:0] AUX_RST = VARIANT_ALT ? AUXCTL_RESET_ALT : AUXCTL_RESET_MAIN;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Serial clock was high a few cycles back, so a byte just ended
  sequence s_scl_recent;
    $past(scl_in, 2) || $past(scl_in, 3);
  endsequence
  // Data pin is only ever pulled low
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  // Run follows enable unless shutdown and not kept
  property p_run;
    aux_ldo_run == (aux_ldo_enable && (!shutdown_req || aux_ldo_shutdown_keep));
  endproperty
  a_run: assert property (p_run) else $error("aux run wrong");
  // Outputs hold reset pattern right after release
  property p_rst;
    $fell(rst) |-> {aux_ldo_discharge_sel, aux_ldo_shutdown_keep, aux_ldo_voltage_code,
      aux_ldo_enable} == AUX_RST && !ddr_term_discharge && !sda_oe && !shutdown_req;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  // Control outputs change only at the end of a written byte
  property p_ctl;
    !$stable({ddr_term_discharge, aux_ldo_discharge_sel, aux_ldo_shutdown_keep,
      aux_ldo_voltage_code, aux_ldo_enable}) |-> s_scl_recent;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control changed unasked");
  // Shutdown rises only from a fault or a mask write
  property p_sd_rise;
    $rose(shutdown_req) |-> ($past(rail_fault_in, 2) != 5'h00) or s_scl_recent;
  endproperty
  a_sd_rise: assert property (p_sd_rise) else $error("shutdown without cause");
  // Shutdown drops only after a host write
  property p_sd_fall; $fell(shutdown_req) |-> s_scl_recent; endproperty
  a_sd_fall: assert property (p_sd_fall) else $error("shutdown dropped alone");
  // Drive changes only while the serial clock is low
  property p_oe_chg; !$stable(sda_oe) |-> !$past(scl_in, 2); endproperty
  a_oe_chg: assert property (p_oe_chg) else $error("data changed with clock high");
  // A driven bit stays driven for at least four cycles
  property p_oe_hold; $rose(sda_oe) |-> sda_oe[*4]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("driven bit too short");
endmodule // rail_regs_chk
bind rail_fault_mask_discharge_regs rail_regs_chk #(.VARIANT_ALT(VARIANT_ALT)) i_chk (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .rail_fault_in(rail_fault_in), .shutdown_req(shutdown_req),
  .ddr_term_discharge(ddr_term_discharge), .aux_ldo_discharge_sel(aux_ldo_discharge_sel),
  .aux_ldo_shutdown_keep(aux_ldo_shutdown_keep), .aux_ldo_voltage_code(aux_ldo_voltage_code),
  .aux_ldo_enable(aux_ldo_enable), .aux_ldo_run(aux_ldo_run));
`default_nettype wire

//--- host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk,      // Bench clock
  input  wire logic sda,      // Resolved data line
  output logic      scl,      // Serial clock
  output logic      sda_pull  // High pulls data low
);
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Wait whole cycles
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: set in low phase, sampled mid high phase
  task automatic slot(input logic b, output logic s);
    sda_pull <= ~b;
    tick(6);
    scl <= 1'b1;
    tick(4);
    s = sda;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  // Start or repeated start
  task automatic start();
    sda_pull <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(8);
    sda_pull <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(2);
  endtask
  // Stop, bus left idle
  task automatic stop();
    sda_pull <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(8);
    sda_pull <= 1'b0;
    tick(8);
  endtask
  // Byte out MSB first, then acknowledge sampled
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask
  // Byte in MSB first, then acknowledge or refuse
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(last, s);
  endtask
endmodule // host_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rail_regs_pkg::*;
  localparam logic [6:0] DEV = 7'h2A;  // Arbitrary slave address
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [4:0] rail_fault_in = 5'h00;
  logic       scl, host_pull, sda_oe, sda_out, shutdown_req, ddr_dis, keep, en, run;
  logic [1:0] dsel;
  logic [3:0] vcode;
  logic       alt_keep, alt_en;
  logic [1:0] alt_dsel;
  logic [3:0] alt_vcode;
  logic [7:0] fbit [5] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20};
  logic [7:0] mbit [5] = '{8'h01, 8'h06, 8'h08, 8'h10, 8'h20};
  int         err_total = 0;
  int         num_checks = 0;
  wire        sda = ~(sda_oe | host_pull);  // Pull-up line
  // 200 MHz clock
  always #2.5 clk = ~clk;
  rail_fault_mask_discharge_regs #(.DEV_ADDR(DEV), .VARIANT_ALT(1'b0))
    i_rail_fault_mask_discharge_regs (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .rail_fault_in(rail_fault_in), .shutdown_req(shutdown_req), .ddr_term_discharge(ddr_dis),
    .aux_ldo_discharge_sel(dsel), .aux_ldo_shutdown_keep(keep), .aux_ldo_voltage_code(vcode),
    .aux_ldo_enable(en), .aux_ldo_run(run));
  host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(host_pull));
  // Second factory variant, bus idle, only its reset pattern is looked at
  rail_fault_mask_discharge_regs #(.DEV_ADDR(DEV), .VARIANT_ALT(1'b1))
    i_rail_fault_mask_discharge_regs_alt (
    .clk(clk), .rst(rst), .scl_in(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe(),
    .rail_fault_in(5'h00), .shutdown_req(), .ddr_term_discharge(),
    .aux_ldo_discharge_sel(alt_dsel), .aux_ldo_shutdown_keep(alt_keep),
    .aux_ldo_voltage_code(alt_vcode), .aux_ldo_enable(alt_en), .aux_ldo_run());
  // Compare and count
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] ack;
    host.start();
    host.put({DEV, 1'b0}, ack[2]);
    host.put(a, ack[1]);
    host.put(d, ack[0]);
    host.stop();
    cmp("write ack", 8'h07, {5'h00, ack});
  endtask
  // Register read through repeated start
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [2:0] ack;
    logic [7:0] d;
    host.start();
    host.put({DEV, 1'b0}, ack[2]);
    host.put(a, ack[1]);
    host.start();
    host.put({DEV, 1'b1}, ack[0]);
    host.get(1'b1, d);
    host.stop();
    cmp("read ack", 8'h07, {5'h00, ack});
    cmp($sformatf("reg %h", a), exp, d);
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    host.tick(5);
    chk(MASK2_ADDR, 8'h37);
    chk(DISCH4_ADDR, 8'h61);
    chk(AUXCTL_ADDR, 8'h7C);
    cmp("aux pins", 8'h7C, {dsel, keep, vcode, en});
    cmp("alt aux pins", 8'h69, {alt_dsel, alt_keep, alt_vcode, alt_en});
    chk(8'hA4, 8'h00);
    $display("test reset values done");
    wr(MASK2_ADDR, 8'hFF);
    chk(MASK2_ADDR, 8'h3F);
    wr(DISCH4_ADDR, 8'hFF);
    chk(DISCH4_ADDR, 8'h71);
    cmp("ddr discharge", 8'h01, ddr_dis);
    wr(DISCH4_ADDR, 8'h00);
    chk(DISCH4_ADDR, 8'h61);
    cmp("ddr discharge", 8'h00, ddr_dis);
    for (int i = 0; i < 4; i++) begin
      wr(AUXCTL_ADDR, {i[1:0], 6'h15 + 6'(i * 9)});
      cmp("aux pins", {i[1:0], 6'h15 + 6'(i * 9)}, {dsel, keep, vcode, en});
    end
    $display("test register writes done");
    for (int r = 0; r < 5; r++) begin
      wr(MASK2_ADDR, mbit[r]);
      wr(AUXCTL_ADDR, r[0] ? 8'h21 : 8'h01);
      rail_fault_in <= 5'h01 << r;
      host.tick(6);
      cmp("shutdown masked", 8'h00, shutdown_req);
      wr(MASK2_ADDR, 8'h00);
      cmp("shutdown", 8'h01, shutdown_req);
      cmp("aux run", {7'h00, r[0]}, run);
      wr(FLAGS_ADDR, 8'hFF);
      chk(FLAGS_ADDR, fbit[r]);
      rail_fault_in <= 5'h00;
      wr(FLAGS_ADDR, 8'hFF);
      chk(FLAGS_ADDR, 8'h00);
      cmp("shutdown", 8'h00, shutdown_req);
    end
    $display("test faults done");
    summarize();
  end
  // Watchdog
  initial begin
    #300000;
    err_total++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
